/* File: core/tfd_decoder.sv */
`timescale 1ns/1ps
`include "tfd_defines.svh"
module tfd_decoder #(
  parameter int BUF_AW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_space_n,
  input wire logic [`TFD_ADDR_W-1:0] host_addr,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_lo,
  output logic host_data_oe_hi,
  input wire logic [7:0] dev_status,
  input wire logic [7:0] dev_error,
  input wire logic [7:0] dev_drive_addr,
  input wire logic dev_xfer_start,
  input wire logic dev_buf_we,
  input wire logic [BUF_AW-1:0] dev_buf_addr,
  input wire logic [15:0] dev_buf_wdata,
  output logic [15:0] dev_buf_rdata,
  output logic [7:0] feature_r,
  output logic [7:0] sector_count_r,
  output logic [7:0] sector_number_r,
  output logic [7:0] cylinder_low_r,
  output logic [7:0] cylinder_high_r,
  output logic [7:0] card_head_select_r,
  output logic [7:0] device_control_r,
  output logic [7:0] command_code_r,
  output logic command_pulse_r,
  output logic [BUF_AW-1:0] word_ptr_r
);

  // ----------------------------------------------------------------
  // address and lane decode
  // ----------------------------------------------------------------

  // memory window: A10 high aliases the data port for block moves
  function automatic logic [3:0] decode_offset(input logic mem_mode,
                                               input logic [`TFD_ADDR_W-1:0] a);
    if (mem_mode && a[`TFD_WIN_BIT]) begin // R1 R11
      decode_offset = a[0] ? `TFD_OFF_DUP_ODD : `TFD_OFF_DUP_EVEN; // R11
    end else begin
      decode_offset = a[3:0]; // R18
    end
  endfunction

  function automatic tfd_pkg::tfd_lane_e decode_lane(input logic lo_n, input logic hi_n);
    case ({hi_n, lo_n})
      2'b00: decode_lane = tfd_pkg::TFD_LANE_WORD;
      2'b10: decode_lane = tfd_pkg::TFD_LANE_LO;
      2'b01: decode_lane = tfd_pkg::TFD_LANE_HI;
      default: decode_lane = tfd_pkg::TFD_LANE_NONE;
    endcase
  endfunction

  logic mem_mode;
  logic [3:0] offset;
  logic [3:0] byte_off;
  tfd_pkg::tfd_lane_e lane;
  logic [3:0] fall;
  logic rd_go;
  logic wr_go;
  logic rd_level;
  logic is_data;
  logic data_word;
  logic data_byte;
  logic byte_is_odd;
  logic [7:0] byte_in;

  // space select picks which strobe pair is live
  assign mem_mode = reg_space_n; // R19
  assign offset = decode_offset(mem_mode, host_addr);
  assign lane = decode_lane(low_byte_enable_n, high_byte_enable_n);

  tfd_strobe_edge #(
    .N(4)
  ) u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .strobe_n({mem_read_strobe_n, mem_write_strobe_n,
               port_read_strobe_n, port_write_strobe_n}),
    .fall_pulse(fall)
  );

  assign rd_go = (mem_mode ? fall[3] : fall[1]) && lane != tfd_pkg::TFD_LANE_NONE;
  assign wr_go = (mem_mode ? fall[2] : fall[0]) && lane != tfd_pkg::TFD_LANE_NONE;
  assign rd_level = mem_mode ? !mem_read_strobe_n : !port_read_strobe_n;

  // high-only byte at an even offset reaches the odd register above it
  assign byte_off = (lane == tfd_pkg::TFD_LANE_HI) ? (offset | 4'h1) : offset;
  assign byte_in = (lane == tfd_pkg::TFD_LANE_HI) ? host_data_in[15:8] : host_data_in[7:0];

  // word at 0, 1, 8 or 9 is the data word; Dh never overlaps data
  assign data_word = lane == tfd_pkg::TFD_LANE_WORD &&
                     (offset == `TFD_OFF_DATA || offset == `TFD_OFF_ERRFEAT ||
                      offset == `TFD_OFF_DUP_EVEN || offset == `TFD_OFF_DUP_ODD); // R2 R5 R8
  // byte data: 0 or 8 on the low lane, 8 or 9 as odd; high lane at 0 is error/feature
  assign data_byte = lane != tfd_pkg::TFD_LANE_WORD &&
                     ((lane == tfd_pkg::TFD_LANE_LO && offset == `TFD_OFF_DATA) ||
                      byte_off == `TFD_OFF_DUP_EVEN || byte_off == `TFD_OFF_DUP_ODD); // R4 R5
  assign is_data = data_word || data_byte;
  assign byte_is_odd = byte_off == `TFD_OFF_DUP_ODD;

  // ----------------------------------------------------------------
  // data buffer sequencing
  // ----------------------------------------------------------------

  logic even_done_r;
  logic odd_done_r;
  logic [15:0] wr_hold_r;
  logic take_odd;
  logic pair_done;
  logic buf_we;
  logic [15:0] buf_wdata;
  logic [15:0] buf_rdata;

  // repeated byte 0/8 walks even then odd; 9 always takes the odd byte
  assign take_odd = byte_is_odd || even_done_r; // R3 R6 R7 R10
  assign pair_done = data_byte && (take_odd ? even_done_r : odd_done_r);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      even_done_r <= 1'b0;
      odd_done_r <= 1'b0;
    end else if (dev_xfer_start || ((rd_go || wr_go) && (data_word || pair_done))) begin
      even_done_r <= 1'b0; // R21
      odd_done_r <= 1'b0;
    end else if ((rd_go || wr_go) && data_byte) begin
      if (take_odd) begin
        odd_done_r <= 1'b1;
      end else begin
        even_done_r <= 1'b1;
      end
    end
  end

  // the window only steps forward, or restarts at 0 on a new transfer: no random buffer access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_ptr_r <= '0;
    end else if (dev_xfer_start) begin
      word_ptr_r <= '0; // R21
    end else if ((rd_go || wr_go) && (data_word || pair_done)) begin
      word_ptr_r <= word_ptr_r + 1'b1; // R1 R7 R8
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_hold_r <= '0;
    end else if (wr_go && data_byte) begin
      if (take_odd) begin
        wr_hold_r[15:8] <= byte_in;
      end else begin
        wr_hold_r[7:0] <= byte_in;
      end
    end
  end

  assign buf_we = wr_go && (data_word || pair_done);
  always_comb begin
    buf_wdata = host_data_in; // R12
    if (data_byte) begin
      buf_wdata = take_odd ? {byte_in, wr_hold_r[7:0]} : {wr_hold_r[15:8], byte_in};
    end
  end

  // read data of the current word are ready one cycle after the pointer moves
  tfd_buf_mem #(
    .AW(BUF_AW),
    .DW(16)
  ) u_buf (
    .clk_sys(clk_sys),
    .a_we(buf_we),
    .a_addr(word_ptr_r),
    .a_wdata(buf_wdata),
    .a_rdata(buf_rdata),
    .b_we(dev_buf_we),
    .b_addr(dev_buf_addr),
    .b_wdata(dev_buf_wdata),
    .b_rdata(dev_buf_rdata)
  );

  // ----------------------------------------------------------------
  // task file registers
  // ----------------------------------------------------------------

  function automatic logic [7:0] reg_read(input logic [3:0] off, input logic [7:0] st,
                                          input logic [7:0] er, input logic [7:0] da,
                                          input logic [7:0] sc, input logic [7:0] sn,
                                          input logic [7:0] cl, input logic [7:0] ch,
                                          input logic [7:0] hd);
    case (off)
      `TFD_OFF_ERRFEAT, `TFD_OFF_DUP_ERR: reg_read = er; // R15 R16
      `TFD_OFF_SECCNT: reg_read = sc; // R13
      `TFD_OFF_SECNUM: reg_read = sn; // R13
      `TFD_OFF_CYLLO: reg_read = cl; // R14
      `TFD_OFF_CYLHI: reg_read = ch; // R14
      `TFD_OFF_HEAD: reg_read = hd; // R14
      `TFD_OFF_STATCMD, `TFD_OFF_ALTCTL: reg_read = st; // R14 R17
      `TFD_OFF_DRVADDR: reg_read = da; // R17
      default: reg_read = `TFD_UNDEF_READ; // R20
    endcase
  endfunction

  // writes to one register address; used for the low and high lane
  logic wr_reg_lo;
  logic wr_reg_hi;
  logic [3:0] off_lo;
  logic [3:0] off_hi;
  logic [7:0] dat_lo;
  logic [7:0] dat_hi;

  assign wr_reg_lo = wr_go && !is_data && lane != tfd_pkg::TFD_LANE_HI;
  assign wr_reg_hi = wr_go && !is_data && lane != tfd_pkg::TFD_LANE_LO;
  // word at Dh carries error/feature on the high lane only
  assign off_lo = (lane != tfd_pkg::TFD_LANE_WORD) ? byte_off :
                  (offset == `TFD_OFF_DUP_ERR) ? 4'ha : {offset[3:1], 1'b0};
  assign off_hi = (lane == tfd_pkg::TFD_LANE_WORD) ? (offset | 4'h1) : byte_off;
  assign dat_lo = host_data_in[7:0];
  assign dat_hi = host_data_in[15:8];

  function automatic logic hits(input logic we_lo, input logic we_hi, input logic [3:0] ol,
                                input logic [3:0] oh, input logic [3:0] target);
    hits = (we_lo && ol == target) || (we_hi && oh == target);
  endfunction

  function automatic logic [7:0] pick(input logic we_lo, input logic [3:0] ol,
                                      input logic [3:0] target, input logic [7:0] dl,
                                      input logic [7:0] dh);
    pick = (we_lo && ol == target) ? dl : dh;
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      feature_r <= `TFD_REG_RESET;
    end else if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_ERRFEAT) ||
                 hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_DUP_ERR)) begin
      feature_r <= (lane == tfd_pkg::TFD_LANE_LO) ? dat_lo : dat_hi; // R4 R15 R16
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sector_count_r <= `TFD_REG_RESET;
      sector_number_r <= `TFD_REG_RESET;
    end else begin
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_SECCNT)) begin
        sector_count_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_SECCNT, dat_lo, dat_hi); // R13
      end
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_SECNUM)) begin
        sector_number_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_SECNUM, dat_lo, dat_hi); // R13
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cylinder_low_r <= `TFD_REG_RESET;
      cylinder_high_r <= `TFD_REG_RESET;
      card_head_select_r <= `TFD_REG_RESET;
    end else begin
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_CYLLO)) begin
        cylinder_low_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_CYLLO, dat_lo, dat_hi); // R14
      end
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_CYLHI)) begin
        cylinder_high_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_CYLHI, dat_lo, dat_hi); // R14
      end
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_HEAD)) begin
        card_head_select_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_HEAD, dat_lo, dat_hi); // R14
      end
    end
  end

  // command write is a one-cycle pulse to the device core
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      command_code_r <= `TFD_REG_RESET;
      command_pulse_r <= 1'b0;
    end else begin
      command_pulse_r <= hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_STATCMD); // R14
      if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_STATCMD)) begin
        command_code_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_STATCMD, dat_lo, dat_hi);
      end
    end
  end

  // Fh writes and Ah-Ch writes fall through with no register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      device_control_r <= `TFD_REG_RESET;
    end else if (hits(wr_reg_lo, wr_reg_hi, off_lo, off_hi, `TFD_OFF_ALTCTL)) begin
      device_control_r <= pick(wr_reg_lo, off_lo, `TFD_OFF_ALTCTL, dat_lo, dat_hi); // R17 R20
    end
  end

  // ----------------------------------------------------------------
  // read data and lane drive
  // ----------------------------------------------------------------

  logic [15:0] rd_word;
  always_comb begin
    rd_word = {reg_read(off_hi, dev_status, dev_error, dev_drive_addr, sector_count_r,
                        sector_number_r, cylinder_low_r, cylinder_high_r, card_head_select_r),
               reg_read(off_lo, dev_status, dev_error, dev_drive_addr, sector_count_r,
                        sector_number_r, cylinder_low_r, cylinder_high_r, card_head_select_r)};
    if (data_word) begin
      rd_word = buf_rdata; // R2 R8 R12
    end else if (data_byte) begin
      // byte is placed on whichever lane the host enabled
      rd_word = take_odd ? {2{buf_rdata[15:8]}} : {2{buf_rdata[7:0]}}; // R3 R6 R10
    end else if (lane == tfd_pkg::TFD_LANE_LO) begin
      rd_word[7:0] = reg_read(byte_off, dev_status, dev_error, dev_drive_addr,
                              sector_count_r, sector_number_r, cylinder_low_r,
                              cylinder_high_r, card_head_select_r);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_data_out <= '0;
    end else if (rd_go) begin
      host_data_out <= rd_word;
    end
  end

  // lanes are driven from the data update until the strobe rises
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_data_oe_lo <= 1'b0;
      host_data_oe_hi <= 1'b0;
    end else if (rd_go) begin
      host_data_oe_lo <= lane != tfd_pkg::TFD_LANE_HI;
      host_data_oe_hi <= lane != tfd_pkg::TFD_LANE_LO;
    end else if (!rd_level) begin
      host_data_oe_lo <= 1'b0;
      host_data_oe_hi <= 1'b0;
    end
  end

endmodule

/* File: core/tfd_defines.svh */
// Overview of operation
// R1: memory window 2 KB, data port sequential only
// R2: both enables low: offset 0 is word
// R3: byte pair at 0: even then odd
// R4: high-only byte at 0 hits error/feature
// R5: 8h, 9h, Dh mirror offsets 0 and 1
// R6: byte 9 then 8 moves odd then even
// R7: repeated byte 8/0 step even, odd, advance
// R8: repeated word 8/9/0 take next word
// R9: host never repeats byte accesses to 9
// R10: alternating byte 8 then 9: even, odd
// R11: 400h-7FFh even to 8h, odd to 9h
// R12: word at 8: even low, odd high lane
// R13: offsets 2h, 3h sector count, number
// R14: 4h-6h cylinder, head; 7h status/command
// R15: offset 1h error read, feature write
// R16: Dh duplicates error/feature, not data
// R17: Eh alt status/control; Fh drive address
// R18: I/O mapping decodes four low bits only
// R19: host drives space select per mapping
// R20: offsets Ah-Ch read zero, writes ignored
// R21: word access or new transfer resets lane
`ifndef TFD_DEFINES_SVH
`define TFD_DEFINES_SVH

`define TFD_ADDR_W 11
`define TFD_WIN_BIT 10
`define TFD_OFF_DATA 4'h0
`define TFD_OFF_ERRFEAT 4'h1
`define TFD_OFF_SECCNT 4'h2
`define TFD_OFF_SECNUM 4'h3
`define TFD_OFF_CYLLO 4'h4
`define TFD_OFF_CYLHI 4'h5
`define TFD_OFF_HEAD 4'h6
`define TFD_OFF_STATCMD 4'h7
`define TFD_OFF_DUP_EVEN 4'h8
`define TFD_OFF_DUP_ODD 4'h9
`define TFD_OFF_DUP_ERR 4'hd
`define TFD_OFF_ALTCTL 4'he
`define TFD_OFF_DRVADDR 4'hf
`define TFD_REG_RESET 8'h00
`define TFD_UNDEF_READ 8'h00

`endif

/* File: core/tfd_pkg.sv */
package tfd_pkg;

  // lane use of one host cycle, from the two byte enables
  typedef enum logic [1:0] {
    TFD_LANE_NONE,
    TFD_LANE_WORD,
    TFD_LANE_LO,
    TFD_LANE_HI
  } tfd_lane_e;

endpackage

/* File: core/tfd_strobe_edge.sv */
`timescale 1ns/1ps
module tfd_strobe_edge #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] strobe_n,
  output logic [N-1:0] fall_pulse
);

  logic [N-1:0] prev_n_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_n_r <= '1;
    end else begin
      prev_n_r <= strobe_n;
    end
  end

  // registered so a strobe edge is acted on exactly once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fall_pulse <= '0;
    end else begin
      fall_pulse <= prev_n_r & ~strobe_n;
    end
  end

endmodule

/* File: core/tfd_buf_mem.sv */
`timescale 1ns/1ps
module tfd_buf_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic clk_sys,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // one write process; host port wins a same-cycle clash
  always_ff @(posedge clk_sys) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end else if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    a_rdata <= mem[a_addr];
  end

  always_ff @(posedge clk_sys) begin
    b_rdata <= mem[b_addr];
  end

endmodule

/* File: sim/tfd_props.sv */
`timescale 1ns/1ps
`include "tfd_defines.svh"
module tfd_props #(
  parameter int BUF_AW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_space_n,
  input wire logic [`TFD_ADDR_W-1:0] host_addr,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic port_read_strobe_n,
  input wire logic host_data_oe_lo,
  input wire logic host_data_oe_hi,
  input wire logic dev_xfer_start,
  input wire logic command_pulse_r,
  input wire logic [BUF_AW-1:0] word_ptr_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // effects are looked at four edges on, once the two-stage answer has surely landed
  chk_word_lanes: assert property (
    $fell(mem_read_strobe_n) && reg_space_n && !low_byte_enable_n && !high_byte_enable_n
    |-> ##4 host_data_oe_lo && host_data_oe_hi) else $error("word read lanes");
  chk_lo_lane: assert property (
    $fell(mem_read_strobe_n) && reg_space_n && !low_byte_enable_n && high_byte_enable_n
    |-> ##4 host_data_oe_lo && !host_data_oe_hi) else $error("low byte lane");
  chk_hi_lane: assert property (
    $fell(mem_read_strobe_n) && reg_space_n && low_byte_enable_n && !high_byte_enable_n
    |-> ##4 !host_data_oe_lo && host_data_oe_hi) else $error("high byte lane");
  chk_oe_release: assert property (
    (mem_read_strobe_n && port_read_strobe_n) [*2]
    |=> !host_data_oe_lo && !host_data_oe_hi) else $error("bus held after strobe");
  chk_space_ignore: assert property (
    $fell(port_read_strobe_n) && reg_space_n && mem_read_strobe_n
    |-> ##4 !host_data_oe_lo && !host_data_oe_hi) else $error("wrong space answered");
  chk_cmd_pulse: assert property (
    $fell(mem_write_strobe_n) && reg_space_n && host_addr == 11'h007
    && !low_byte_enable_n && high_byte_enable_n
    |-> ##2 $rose(command_pulse_r) ##1 !command_pulse_r) else $error("command pulse");
  chk_ptr_step: assert property (
    $changed(word_ptr_r) |-> word_ptr_r == $past(word_ptr_r) + 1'b1 || word_ptr_r == '0)
    else $error("pointer jumped");
  chk_ptr_word: assert property (
    $fell(mem_read_strobe_n) && reg_space_n && host_addr == 11'h000
    && !low_byte_enable_n && !high_byte_enable_n
    |-> ##4 word_ptr_r == $past(word_ptr_r, 4) + 1'b1) else $error("word step");
  chk_xfer_reset: assert property (
    dev_xfer_start |-> ##[1:2] word_ptr_r == '0) else $error("pointer not cleared");
endmodule

bind tfd_decoder tfd_props #(.BUF_AW(BUF_AW)) tfd_props_inst (.*);

/* File: sim/tfd_host_model.sv */
`timescale 1ns/1ps
module tfd_host_model (
  input wire logic clk_sys,
  output logic reg_space_n,
  output logic [10:0] host_addr,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic port_read_strobe_n,
  output logic port_write_strobe_n,
  output logic [15:0] host_data_in,
  input wire logic [15:0] host_data_out
);
  logic [3:0] strb_n = 4'hf;
  assign {port_write_strobe_n, port_read_strobe_n, mem_write_strobe_n, mem_read_strobe_n} = strb_n;
  initial begin
    reg_space_n = 1'b1;
    host_addr = 11'h000;
    {high_byte_enable_n, low_byte_enable_n} = 2'b11;
    host_data_in = 16'hffff;
  end
  // -----------
  // bus cycle
  // -----------
  // no ready line: strobe held five edges so the registered answer is in place
  task automatic acc(input logic sp_n, input logic [1:0] st, input logic [10:0] a,
                     input logic [1:0] en_n, input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk_sys);
    reg_space_n = sp_n;
    host_addr = a;
    {high_byte_enable_n, low_byte_enable_n} = en_n;
    host_data_in = wd;
    strb_n = ~(4'h1 << st);
    repeat (5) @(negedge clk_sys);
    rd = host_data_out;
    strb_n = 4'hf;
    {high_byte_enable_n, low_byte_enable_n} = 2'b11;
    // a released bus shows the inverse so a stale value cannot pass
    host_data_in = ~wd;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_space_n, low_byte_enable_n, high_byte_enable_n, mem_read_strobe_n;
  logic mem_write_strobe_n, port_read_strobe_n, port_write_strobe_n;
  logic [10:0] host_addr;
  logic [15:0] host_data_in, host_data_out, dev_buf_rdata, rdv, e;
  logic host_data_oe_lo, host_data_oe_hi, command_pulse_r;
  logic dev_xfer_start = 1'b0;
  logic dev_buf_we = 1'b0;
  logic [7:0] dev_buf_addr = 8'h00;
  logic [15:0] dev_buf_wdata = 16'h0000;
  logic [7:0] dev_status = 8'h5a;
  logic [7:0] dev_error = 8'h3c;
  logic [7:0] dev_drive_addr = 8'hc3;
  logic [7:0] word_ptr_r, feature_r, sector_count_r, sector_number_r, cylinder_low_r;
  logic [7:0] cylinder_high_r, card_head_select_r, device_control_r, command_code_r;
  logic [63:0] snap;
  logic [15:0] wexp [3] = '{16'h2211, 16'hbeef, 16'h3344};
  int n_mismatch = 0;
  int total_checks = 0;
  wire [39:0] rq = {card_head_select_r, cylinder_high_r, cylinder_low_r, sector_number_r,
                    sector_count_r};
  always #50 clk_sys = ~clk_sys;
  tfd_decoder #(.BUF_AW(8)) tfd_decoder_inst (.*);
  tfd_host_model tfd_host_model_inst (.*);
  function automatic logic [15:0] bw(input int i);
    return 16'hb040 + 16'h0101 * i[15:0];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic io, input logic wr, input logic [10:0] a,
                      input logic [1:0] en, input logic [15:0] wd);
    tfd_host_model_inst.acc(~io, {io, wr}, a, en, wd, rdv);
  endtask
  task automatic start_xfer;
    dev_xfer_start = 1'b1;
    @(negedge clk_sys);
    dev_xfer_start = 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // about fifty bus cycles of eight clocks each; twelve and a half times that is a hang
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
  // -----------
  // main sequence
  // -----------
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    check({rq, feature_r, device_control_r, command_code_r}, 64'h0);
    check({word_ptr_r, host_data_oe_hi, host_data_oe_lo}, 64'h0);
    for (int i = 0; i < 8; i++) begin
      dev_buf_we = 1'b1;
      dev_buf_addr = 8'(i);
      dev_buf_wdata = bw(i);
      @(negedge clk_sys);
    end
    dev_buf_we = 1'b0;
    start_xfer();
    xfer(0, 0, 11'h000, 2'b00, 16'h0);
    check(rdv, bw(0));
    xfer(0, 0, 11'h008, 2'b00, 16'h0);
    check(rdv, bw(1));
    xfer(1, 0, 11'h7f9, 2'b00, 16'h0);
    check(rdv, bw(2));
    e = bw(3);
    xfer(0, 0, 11'h000, 2'b10, 16'h0);
    check(rdv[7:0], e[7:0]);
    xfer(0, 0, 11'h000, 2'b10, 16'h0);
    check(rdv[7:0], e[15:8]);
    e = bw(4);
    xfer(1, 0, 11'h009, 2'b10, 16'h0);
    check(rdv[7:0], e[15:8]);
    xfer(1, 0, 11'h008, 2'b10, 16'h0);
    check(rdv[7:0], e[7:0]);
    e = bw(5);
    xfer(0, 0, 11'h400, 2'b10, 16'h0);
    check(rdv[7:0], e[7:0]);
    xfer(0, 0, 11'h7ff, 2'b10, 16'h0);
    check(rdv[7:0], e[15:8]);
    check(word_ptr_r, 8'h06);
    xfer(0, 0, 11'h000, 2'b10, 16'h0);
    start_xfer();
    check(word_ptr_r, 8'h00);
    e = bw(0);
    xfer(0, 0, 11'h000, 2'b10, 16'h0);
    check(rdv[7:0], e[7:0]);
    start_xfer();
    // odd byte 9h is never repeated, that ordering has no defined result
    xfer(0, 1, 11'h008, 2'b10, 16'h0011);
    xfer(0, 1, 11'h009, 2'b10, 16'h0022);
    xfer(1, 1, 11'h000, 2'b00, 16'hbeef);
    xfer(1, 1, 11'h008, 2'b01, 16'h3300);
    xfer(1, 1, 11'h000, 2'b10, 16'h0044);
    check(word_ptr_r, 8'h03);
    for (int i = 0; i < 3; i++) begin
      dev_buf_addr = 8'(i);
      repeat (2) @(negedge clk_sys);
      check(dev_buf_rdata, wexp[i]);
    end
    for (int i = 2; i < 7; i++) begin
      xfer(i[0], 1, 11'h3f0 | 11'(i), 2'b10, 16'h00a0 + 16'(i));
      xfer(~i[0], 0, 11'(i), 2'b10, 16'h0);
      check(rdv[7:0], 8'ha0 + 8'(i));
      check(rq[(i-2)*8 +: 8], 8'ha0 + 8'(i));
    end
    xfer(0, 1, 11'h004, 2'b00, 16'h9a5b);
    check({cylinder_high_r, cylinder_low_r}, 16'h9a5b);
    xfer(0, 1, 11'h007, 2'b10, 16'h00ec);
    check(command_code_r, 8'hec);
    xfer(1, 0, 11'h007, 2'b10, 16'h0);
    check(rdv[7:0], dev_status);
    xfer(1, 1, 11'h001, 2'b10, 16'h0011);
    check(feature_r, 8'h11);
    xfer(0, 0, 11'h001, 2'b10, 16'h0);
    check(rdv[7:0], dev_error);
    xfer(0, 1, 11'h00d, 2'b10, 16'h0022);
    check(feature_r, 8'h22);
    xfer(1, 0, 11'h00d, 2'b00, 16'h0);
    check(rdv[15:8], dev_error);
    xfer(1, 1, 11'h000, 2'b01, 16'h5500);
    check(feature_r, 8'h55);
    xfer(0, 0, 11'h000, 2'b01, 16'h0);
    check(rdv[15:8], dev_error);
    check(word_ptr_r, 8'h03);
    xfer(0, 1, 11'h00e, 2'b10, 16'h0006);
    check(device_control_r, 8'h06);
    xfer(1, 0, 11'h00e, 2'b10, 16'h0);
    check(rdv[7:0], dev_status);
    xfer(0, 0, 11'h00f, 2'b10, 16'h0);
    check(rdv[7:0], dev_drive_addr);
    snap = {rq, feature_r, device_control_r, command_code_r};
    xfer(1, 1, 11'h00f, 2'b10, 16'h00ff);
    check({rq, feature_r, device_control_r, command_code_r}, snap);
    for (int i = 10; i < 13; i++) begin
      xfer(i[0], 1, 11'(i), 2'b10, 16'h00ff);
      xfer(i[0], 0, 11'(i), 2'b10, 16'h0);
      check(rdv[7:0], 8'h00);
    end
    check({rq, feature_r, device_control_r, command_code_r}, snap);
    check(word_ptr_r, 8'h03);
    tfd_host_model_inst.acc(1'b1, 2'd3, 11'h002, 2'b10, 16'h00ff, rdv);
    tfd_host_model_inst.acc(1'b1, 2'd2, 11'h007, 2'b10, 16'h0000, rdv);
    check({rq, feature_r, device_control_r, command_code_r}, snap);
    summarize();
  end
endmodule
